// ### hdl/los_recip.v
/*
 * Serial reciprocal unit: computes 1.0 / den in Q16 by restoring division.
 * Assumes den is a signed Q16 voltage; a result that overflows saturates.
 */
`include "los_regs.vh"
`default_nettype none

module los_recip #(
   parameter QW = 33
) (
   input wire clk_i,
   input wire nrst_i,
   input wire start_i,
   input wire [31:0] den_i,
   output reg done_o,
   output reg [31:0] quo_o
);

   reg [5:0] cnt_q;
   reg busy_q;
   reg neg_q;
   reg [31:0] dv_q;
   reg [33:0] rem_q;
   reg [QW-1:0] q_q;
   wire [33:0] trial;
   wire [QW-1:0] q_d;

   // Numerator is 2^32, so only the first shifted-in bit is a one.
   assign trial = {rem_q[32:0], (cnt_q == QW[5:0] - 6'h01)};
   assign q_d = {q_q[QW-2:0], (trial >= {2'b00, dv_q})};

   // ============================================================
   // Division sequencer, one quotient bit per cycle.
   always @(posedge clk_i) begin
      if (!nrst_i) begin
         cnt_q <= 6'h00;
         busy_q <= 1'b0;
         neg_q <= 1'b0;
         dv_q <= 32'h00000000;
         rem_q <= 34'h000000000;
         q_q <= {QW{1'b0}};
         done_o <= 1'b0;
         quo_o <= 32'h00000000;
      end else begin
         done_o <= 1'b0;
         if (start_i && !busy_q) begin
            busy_q <= 1'b1;
            cnt_q <= QW[5:0] - 6'h01;
            neg_q <= den_i[31];
            dv_q <= den_i[31] ? (~den_i + 32'h00000001) : den_i;
            rem_q <= 34'h000000000;
         end else if (busy_q) begin
            q_q <= q_d;
            rem_q <= (trial >= {2'b00, dv_q}) ? (trial - {2'b00, dv_q}) : trial;
            cnt_q <= cnt_q - 6'h01;
            if (cnt_q == 6'h00) begin
               busy_q <= 1'b0;
               done_o <= 1'b1;
               // A zero or tiny divisor pins the reciprocal at its limit.
               if (dv_q == 32'h00000000 || |q_d[QW-1:31])
                  quo_o <= neg_q ? ~`LOS_SAT_POS : `LOS_SAT_POS;
               else
                  quo_o <= neg_q ? (~q_d[31:0] + 32'h00000001) : q_d[31:0];
            end
         end
      end
   end

endmodule
`default_nettype wire

// ### hdl/los_top.v
/*
 * Output scaling datapath of a lock-in amplifier: turns the X, Y, R and phase
 * results into converter codes, display values, chart values and indicators.
 * Assumes all inputs are synchronous to clk_i, X/Y/R/aux are signed Q16 values
 * and phase is a binary angle in which 16'h8000 stands for -180 degrees.
 */
// The implementer's own choices: the register offsets and the plain strobed port.
`include "los_regs.vh"
`default_nettype none

module los_top #(
   parameter UPD_CYC = `LOS_UPD_CYC
) (
   input wire clk_i,
   input wire nrst_i,
   input wire [7:0] addr_i,
   input wire [31:0] wdata_i,
   input wire we_i,
   input wire re_i,
   output reg [31:0] rdata_o,
   input wire [31:0] x_i,
   input wire [31:0] y_i,
   input wire [31:0] r_i,
   input wire [15:0] phase_i,
   input wire [31:0] aux3_i,
   input wire [31:0] aux4_i,
   output reg sample_o,
   output reg [15:0] rear_x_o,
   output reg [15:0] rear_y_o,
   output reg [15:0] front_output_one_o,
   output reg [15:0] front_output_two_o,
   output reg [15:0] bar_r_o,
   output reg [`LOS_NOVL-1:0] ovld_o,
   output reg ratio_lamp_o,
   output reg [2:0] ofs_ind_o,
   output reg [2:0] ratio_ind_o,
   output reg [2:0] exp_ind_o,
   output reg irq_o
);

   localparam [5:0] TICK_LAST = UPD_CYC[5:0] - 6'h01;

   // ============================================================
   // Functions

   // Clamps a written offset percentage into the programmable range.
   function [10:0] los_pct;
      input [10:0] p;
      begin
         if ($signed(p) > $signed(`LOS_PCT_MAX))
            los_pct = `LOS_PCT_MAX;
         else if ($signed(p) < $signed(`LOS_PCT_MIN))
            los_pct = `LOS_PCT_MIN;
         else
            los_pct = p;
      end
   endfunction

   // Normalises to sensitivity, removes the offset and applies the ratio term.
   function [47:0] los_corr;
      input [31:0] v;
      input [31:0] g;
      input [10:0] p;
      input [31:0] rc;
      reg signed [63:0] n;
      reg signed [63:0] d;
      reg signed [95:0] q;
      begin
         n = ($signed(v) * $signed({1'b0, g})) >>> `LOS_Q;
         d = n - (($signed(p) * $signed({1'b0, `LOS_PCT_K})) >>> `LOS_PCT_SH);
         q = (d * $signed(rc)) >>> `LOS_Q;
         los_corr = q[47:0];
      end
   endfunction

   // Expands and converts to a converter code; bit 16 flags a clamp.
   function [16:0] los_code;
      input [47:0] e;
      input [1:0] ex;
      reg signed [63:0] m;
      reg signed [79:0] c;
      begin
         if (ex == `LOS_EXP_X10)
            m = $signed(e) * $signed({1'b0, `LOS_MUL10});
         else if (ex == `LOS_EXP_X100)
            m = $signed(e) * $signed({1'b0, `LOS_MUL100});
         else
            m = $signed(e);
         c = (m * $signed({1'b0, `LOS_FS})) >>> `LOS_Q;
         if (c > $signed({1'b0, `LOS_FS}))
            los_code = {1'b1, `LOS_FS};
         else if (c < -$signed({1'b0, `LOS_FS}))
            los_code = {1'b1, `LOS_FS_NEG};
         else
            los_code = {1'b0, c[15:0]};
      end
   endfunction

   // Pins a readout at plus or minus one full sensitivity.
   function [31:0] los_disp;
      input [47:0] e;
      begin
         if ($signed(e) > $signed({1'b0, `LOS_ONE}))
            los_disp = `LOS_ONE;
         else if ($signed(e) < -$signed({1'b0, `LOS_ONE}))
            los_disp = ~`LOS_ONE + 32'h00000001;
         else
            los_disp = e[31:0];
      end
   endfunction

   // Saturates a chart value to 32 bits without any sensitivity limit.
   function [31:0] los_sat;
      input [47:0] e;
      begin
         if ($signed(e) > $signed({1'b0, `LOS_SAT_POS}))
            los_sat = `LOS_SAT_POS;
         else if ($signed(e) < -$signed({1'b0, `LOS_SAT_POS}))
            los_sat = ~`LOS_SAT_POS;
         else
            los_sat = e[31:0];
      end
   endfunction

   // ============================================================
   // Registers and state
   reg [5:0] tick_cnt_q;
   reg tick_q;
   reg [`LOS_CTRL_W-1:0] ctrl_q;
   reg [31:0] gain_q;
   reg [10:0] ofs_x_q;
   reg [10:0] ofs_y_q;
   reg [10:0] ofs_r_q;
   reg [`LOS_NOVL-1:0] sts_q;
   reg [`LOS_NOVL-1:0] sts_d;
   reg [`LOS_NOVL-1:0] mask_q;
   reg [31:0] disp_x_q;
   reg [31:0] disp_y_q;
   reg [31:0] disp_r_q;
   reg [31:0] chart_x_q;
   reg [31:0] chart_y_q;
   reg [31:0] chart_r_q;
   reg [31:0] recip3_q;
   reg [31:0] recip4_q;
   reg aux_sel_q;
   reg div_go_q;
   reg [31:0] rd_d;
   wire div_done;
   wire [31:0] div_quo;
   wire wr_sts;
   wire ratio_en;
   wire [31:0] rat_xy;
   wire [31:0] rat_r;
   wire [47:0] ex;
   wire [47:0] ey;
   wire [47:0] er;
   wire [16:0] cx;
   wire [16:0] cy;
   wire [16:0] cr;
   wire [15:0] ph_code;
   wire [`LOS_NOVL-1:0] ovl_d;

   // ============================================================
   // Update-rate divider: one enable pulse per output sample.
   always @(posedge clk_i) begin
      if (!nrst_i) begin
         tick_cnt_q <= 6'h00;
         tick_q <= 1'b0;
      end else begin
         tick_q <= (tick_cnt_q == TICK_LAST);
         tick_cnt_q <= (tick_cnt_q == TICK_LAST) ? 6'h00 : tick_cnt_q + 6'h01;
      end
   end

   // ============================================================
   // Ratio reciprocals: aux three and four are divided in turn, free running.
   los_recip #(
      .QW(33)
   ) u_recip (
      .clk_i(clk_i),
      .nrst_i(nrst_i),
      .start_i(div_go_q),
      .den_i(aux_sel_q ? aux4_i : aux3_i),
      .done_o(div_done),
      .quo_o(div_quo)
   );

   // Keeps the latest reciprocal of each auxiliary input.
   always @(posedge clk_i) begin
      if (!nrst_i) begin
         recip3_q <= `LOS_ONE;
         recip4_q <= `LOS_ONE;
         aux_sel_q <= 1'b0;
         div_go_q <= 1'b1;
      end else begin
         div_go_q <= div_done;
         if (div_done) begin
            aux_sel_q <= ~aux_sel_q;
            if (aux_sel_q)
               recip4_q <= div_quo;
            else
               recip3_q <= div_quo;
         end
      end
   end

   // ============================================================
   // Datapath: the inputs are RMS values and pass through unchanged in kind.
   assign ratio_en = ctrl_q[`LOS_CTRL_RATIO];
   assign rat_xy = ratio_en ? recip3_q : `LOS_ONE;
   assign rat_r = ratio_en ? recip4_q : `LOS_ONE;
   assign ex = los_corr(x_i, gain_q, ofs_x_q, rat_xy);
   assign ey = los_corr(y_i, gain_q, ofs_y_q, rat_xy);
   assign er = los_corr(r_i, gain_q, ofs_r_q, rat_r);
   assign cx = los_code(ex, ctrl_q[`LOS_CTRL_EXPX_LSB +: 2]);
   assign cy = los_code(ey, ctrl_q[`LOS_CTRL_EXPY_LSB +: 2]);
   assign cr = los_code(er, ctrl_q[`LOS_CTRL_EXPR_LSB +: 2]);
   // Phase needs no offset or gain: +-180 degrees is already +-10 V.
   assign ph_code = (phase_i == `LOS_PH_MIN) ? `LOS_FS_NEG : phase_i;
   // Overload order: rear X, rear Y, R, front one, front two.
   assign ovl_d = {ctrl_q[`LOS_CTRL_SEL2] ? 1'b0 : cy[16],
                   ctrl_q[`LOS_CTRL_SEL1] ? cr[16] : cx[16],
                   cr[16], cy[16], cx[16]};

   // Registers every code, overload, display and chart value once per sample tick.
   always @(posedge clk_i) begin
      if (!nrst_i) begin
         sample_o <= 1'b0;
         rear_x_o <= 16'h0000;
         rear_y_o <= 16'h0000;
         front_output_one_o <= 16'h0000;
         front_output_two_o <= 16'h0000;
         bar_r_o <= 16'h0000;
         ovld_o <= {`LOS_NOVL{1'b0}};
         disp_x_q <= 32'h00000000;
         disp_y_q <= 32'h00000000;
         disp_r_q <= 32'h00000000;
         chart_x_q <= 32'h00000000;
         chart_y_q <= 32'h00000000;
         chart_r_q <= 32'h00000000;
      end else begin
         sample_o <= tick_q;
         if (tick_q) begin
            rear_x_o <= cx[15:0];
            rear_y_o <= cy[15:0];
            front_output_one_o <= ctrl_q[`LOS_CTRL_SEL1] ? cr[15:0] : cx[15:0];
            front_output_two_o <= ctrl_q[`LOS_CTRL_SEL2] ? ph_code : cy[15:0];
            bar_r_o <= cr[15:0];
            ovld_o <= ovl_d;
            disp_x_q <= los_disp(ex);
            disp_y_q <= los_disp(ey);
            disp_r_q <= los_disp(er);
            chart_x_q <= los_sat(ex);
            chart_y_q <= los_sat(ey);
            chart_r_q <= los_sat(er);
         end
      end
   end

   // ============================================================
   // Indicators follow the settings that touch each quantity; expand code 3 is unity, so only 1 and 2 light.
   always @(posedge clk_i) begin
      if (!nrst_i) begin
         ratio_lamp_o <= 1'b0;
         ofs_ind_o <= 3'h0;
         ratio_ind_o <= 3'h0;
         exp_ind_o <= 3'h0;
      end else begin
         ratio_lamp_o <= ratio_en;
         ofs_ind_o <= {ofs_r_q != 11'h000, ofs_y_q != 11'h000, ofs_x_q != 11'h000};
         ratio_ind_o <= {ratio_en && rat_r != `LOS_ONE, {2{ratio_en && rat_xy != `LOS_ONE}}};
         exp_ind_o <= {^ctrl_q[`LOS_CTRL_EXPR_LSB +: 2],
                       ^ctrl_q[`LOS_CTRL_EXPY_LSB +: 2],
                       ^ctrl_q[`LOS_CTRL_EXPX_LSB +: 2]};
      end
   end

   // ============================================================
   // Register writes; offsets keep their percentage whatever the gain.
   assign wr_sts = we_i && (addr_i == `LOS_ADDR_STS);

   always @(posedge clk_i) begin
      if (!nrst_i) begin
         ctrl_q <= `LOS_CTRL_RST;
         gain_q <= `LOS_GAIN_RST;
         ofs_x_q <= 11'h000;
         ofs_y_q <= 11'h000;
         ofs_r_q <= 11'h000;
         mask_q <= {`LOS_NOVL{1'b0}};
      end else if (we_i) begin
         case (addr_i)
            `LOS_ADDR_CTRL: ctrl_q <= wdata_i[`LOS_CTRL_W-1:0];
            `LOS_ADDR_GAIN: gain_q <= wdata_i;
            `LOS_ADDR_OFS_X: ofs_x_q <= los_pct(wdata_i[10:0]);
            `LOS_ADDR_OFS_Y: ofs_y_q <= los_pct(wdata_i[10:0]);
            `LOS_ADDR_OFS_R: ofs_r_q <= los_pct(wdata_i[10:0]);
            `LOS_ADDR_MASK: mask_q <= wdata_i[`LOS_NOVL-1:0];
            default: ;
         endcase
      end
   end

   // Sticky overload events: a new event wins over a write-one clear.
   always @* begin
      sts_d = sts_q & ~(wr_sts ? wdata_i[`LOS_NOVL-1:0] : {`LOS_NOVL{1'b0}});
      if (tick_q)
         sts_d = sts_d | ovl_d;
   end

   // Holds the sticky status and the level interrupt.
   always @(posedge clk_i) begin
      if (!nrst_i) begin
         sts_q <= {`LOS_NOVL{1'b0}};
         irq_o <= 1'b0;
      end else begin
         sts_q <= sts_d;
         irq_o <= |(sts_d & mask_q);
      end
   end

   // ============================================================
   // Read decode; unmapped addresses read as zero.
   always @* begin
      rd_d = 32'h00000000;
      case (addr_i)
         `LOS_ADDR_CTRL: rd_d[`LOS_CTRL_W-1:0] = ctrl_q;
         `LOS_ADDR_GAIN: rd_d = gain_q;
         `LOS_ADDR_OFS_X: rd_d = {{21{ofs_x_q[10]}}, ofs_x_q};
         `LOS_ADDR_OFS_Y: rd_d = {{21{ofs_y_q[10]}}, ofs_y_q};
         `LOS_ADDR_OFS_R: rd_d = {{21{ofs_r_q[10]}}, ofs_r_q};
         `LOS_ADDR_STS: rd_d[`LOS_NOVL-1:0] = sts_q;
         `LOS_ADDR_MASK: rd_d[`LOS_NOVL-1:0] = mask_q;
         `LOS_ADDR_LIVE: begin
            rd_d[`LOS_NOVL-1:0] = ovld_o;
            rd_d[`LOS_LIVE_OFS_LSB +: 3] = ofs_ind_o;
            rd_d[`LOS_LIVE_RAT_LSB +: 3] = ratio_ind_o;
            rd_d[`LOS_LIVE_EXP_LSB +: 3] = exp_ind_o;
            rd_d[`LOS_LIVE_LAMP] = ratio_lamp_o;
         end
         `LOS_ADDR_DISP_X: rd_d = disp_x_q;
         `LOS_ADDR_DISP_Y: rd_d = disp_y_q;
         `LOS_ADDR_DISP_R: rd_d = disp_r_q;
         `LOS_ADDR_CHART_X: rd_d = chart_x_q;
         `LOS_ADDR_CHART_Y: rd_d = chart_y_q;
         `LOS_ADDR_CHART_R: rd_d = chart_r_q;
         `LOS_ADDR_RECIP3: rd_d = recip3_q;
         `LOS_ADDR_RECIP4: rd_d = recip4_q;
         default: rd_d = 32'h00000000;
      endcase
   end

   // Read data stands only in the cycle after the read strobe.
   always @(posedge clk_i) begin
      if (!nrst_i)
         rdata_o <= 32'h00000000;
      else
         rdata_o <= re_i ? rd_d : 32'h00000000;
   end

endmodule
`default_nettype wire

// ### inc/los_regs.vh
/*
 * Register map, field positions, reset values and timing constants of the
 * lock-in output scaling block.
 * Assumes a 100 MHz system clock and Q16 fixed point for every normalised value.
 */
`ifndef LOS_REGS_VH
`define LOS_REGS_VH

// ============================================================
// Register byte addresses
`define LOS_ADDR_CTRL 8'h00
`define LOS_ADDR_GAIN 8'h04
`define LOS_ADDR_OFS_X 8'h08
`define LOS_ADDR_OFS_Y 8'h0C
`define LOS_ADDR_OFS_R 8'h10
`define LOS_ADDR_STS 8'h14
`define LOS_ADDR_MASK 8'h18
`define LOS_ADDR_LIVE 8'h1C
`define LOS_ADDR_DISP_X 8'h20
`define LOS_ADDR_DISP_Y 8'h24
`define LOS_ADDR_DISP_R 8'h28
`define LOS_ADDR_CHART_X 8'h2C
`define LOS_ADDR_CHART_Y 8'h30
`define LOS_ADDR_CHART_R 8'h34
`define LOS_ADDR_RECIP3 8'h38
`define LOS_ADDR_RECIP4 8'h3C

// ============================================================
// Control register fields
`define LOS_CTRL_W 10
`define LOS_CTRL_RST 10'h000
`define LOS_CTRL_RATIO 0
`define LOS_CTRL_SEL1 1
`define LOS_CTRL_SEL2 2
`define LOS_CTRL_EXPX_LSB 4
`define LOS_CTRL_EXPY_LSB 6
`define LOS_CTRL_EXPR_LSB 8

// Expand codes and their factors.
`define LOS_EXP_X10 2'h1
`define LOS_EXP_X100 2'h2
`define LOS_MUL10 8'h0A
`define LOS_MUL100 8'h64

// ============================================================
// Live status layout and overload vector width
`define LOS_NOVL 5
`define LOS_LIVE_OFS_LSB 5
`define LOS_LIVE_RAT_LSB 8
`define LOS_LIVE_EXP_LSB 11
`define LOS_LIVE_LAMP 14

// ============================================================
// Number formats
`define LOS_Q 16
`define LOS_ONE 32'h00010000
`define LOS_GAIN_RST 32'h00010000
`define LOS_PCT_MAX 11'h3E7
`define LOS_PCT_MIN 11'h419
`define LOS_PCT_K 20'h28F5C
`define LOS_PCT_SH 8
`define LOS_FS 16'h7FFF
`define LOS_FS_NEG 16'h8001
`define LOS_PH_MIN 16'h8000
`define LOS_SAT_POS 32'h7FFFFFFF

// ============================================================
// Output update timing
`define LOS_CLK_KHZ 100000
`define LOS_UPD_KHZ 2222
`define LOS_UPD_CYC (`LOS_CLK_KHZ / `LOS_UPD_KHZ)

`endif

// ### tb/los_dac_model.sv
/* Model of the two output converters that take the front codes.
   Assumes codes are valid in the cycle of the update strobe. */
`default_nettype none
module los_dac_model (
   input wire logic clk_i,
   input wire logic sample_i,
   input wire logic [15:0] code1_i,
   input wire logic [15:0] code2_i,
   output logic upd_o,
   output logic [15:0] held1_o,
   output logic [15:0] held2_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // Both converters latch together on each update strobe.
   always_ff @(posedge clk_i) begin
      upd_o <= sample_i;
      if (sample_i) begin
         held1_o <= code1_i;
         held2_o <= code2_i;
      end
   end
endmodule
`default_nettype wire

// ### tb/los_top_sva.sv
/* Concurrent checks of the output scaling block, bound to its top module.
   Assumes the register header is on the include path and one clock domain. */
`include "los_regs.vh"
`default_nettype none
module los_top_sva #(
   parameter int UPD_CYC = 45
) (
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic [7:0] addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic we_i,
   input wire logic re_i,
   input wire logic [31:0] rdata_o,
   input wire logic sample_o,
   input wire logic [15:0] rear_x_o,
   input wire logic [15:0] rear_y_o,
   input wire logic [15:0] front_output_one_o,
   input wire logic [15:0] front_output_two_o,
   input wire logic [4:0] ovld_o,
   input wire logic ratio_lamp_o,
   input wire logic irq_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] cnt_q;
   logic seen_q;
   logic [9:0] ctl_q;
   logic [4:0] mask_q;
   // ============================================================
   // Mirrors of the update spacing and of the control and mask writes.
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         cnt_q <= 16'h0000;
         seen_q <= 1'b0;
         ctl_q <= 10'h000;
         mask_q <= 5'h00;
      end else begin
         cnt_q <= sample_o ? 16'h0000 : cnt_q + 16'h0001;
         seen_q <= seen_q | sample_o;
         if (we_i && addr_i == `LOS_ADDR_CTRL) ctl_q <= wdata_i[9:0];
         if (we_i && addr_i == `LOS_ADDR_MASK) mask_q <= wdata_i[4:0];
      end
   end
   // ============================================================
   // Assertions; the selects must be steady across the tick to compare codes.
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!nrst_i);
   sequence ctrl_wr;
      we_i && addr_i == `LOS_ADDR_CTRL;
   endsequence
   sequence sel_x_held;
      !ctl_q[1] && !$past(ctl_q[1]) && !$past(ctl_q[1], 2);
   endsequence
   sequence sel_y_held;
      !ctl_q[2] && !$past(ctl_q[2]) && !$past(ctl_q[2], 2);
   endsequence
   update_period_a: assert property (sample_o && seen_q |-> cnt_q == UPD_CYC - 1)
      else $error("update spacing wrong");
   codes_hold_a: assert property (!sample_o |-> $stable(front_output_one_o) && $stable(ovld_o))
      else $error("codes moved between updates");
   x_duplicate_a: assert property (sample_o ##0 sel_x_held |-> front_output_one_o == rear_x_o)
      else $error("front one differs from rear X");
   y_duplicate_a: assert property (sample_o ##0 sel_y_held |-> front_output_two_o == rear_y_o)
      else $error("front two differs from rear Y");
   ovld_pinned_a: assert property (sample_o && ovld_o[0] |-> rear_x_o inside {`LOS_FS, `LOS_FS_NEG})
      else $error("overloaded X not pinned");
   code_range_a: assert property (front_output_one_o != 16'h8000 && rear_x_o != 16'h8000)
      else $error("code beyond full scale");
   phase_no_ovld_a: assert property (sample_o && ctl_q[2] && $past(ctl_q[2]) && $past(ctl_q[2], 2) |-> !ovld_o[4])
      else $error("phase output overloaded");
   lamp_follow_a: assert property (ctrl_wr |-> ##2 ratio_lamp_o == $past(wdata_i[0], 2))
      else $error("ratio lamp wrong");
   read_idle_a: assert property (!$past(re_i) |-> rdata_o == 32'h00000000)
      else $error("read data outside its cycle");
   irq_masked_a: assert property (irq_o |-> $past(mask_q) != 5'h00)
      else $error("interrupt with all sources masked");
endmodule
bind los_top los_top_sva #(.UPD_CYC(UPD_CYC)) i_sva (.clk_i, .nrst_i, .addr_i, .wdata_i, .we_i, .re_i, .rdata_o,
   .sample_o, .rear_x_o, .rear_y_o, .front_output_one_o, .front_output_two_o, .ovld_o, .ratio_lamp_o, .irq_o);
`default_nettype wire

// ### tb/tb_lockin_output_scaling.sv
/* Self-checking bench of the output scaling block with a converter model.
   Assumes the register header is on the include path. */
`include "los_regs.vh"
`default_nettype none
module tb_lockin_output_scaling;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {logic [15:0] f1; logic [15:0] f2; logic [4:0] ov;} los_exp_t;
   logic clk_i = 1'b0, nrst_i = 1'b0, we_i = 1'b0, re_i = 1'b0, re_d = 1'b0;
   logic [7:0] addr_i = 8'h00;
   logic [31:0] wdata_i = 32'h0, x_i = 32'h0, y_i = 32'h0, r_i = 32'h0, seed = 32'h00014136;
   logic [31:0] aux3_i = 32'h00020000, aux4_i = `LOS_ONE;
   logic [15:0] phase_i = 16'h0000;
   wire [31:0] rdata_o;
   wire [15:0] rx, ry, f1, f2, bar, dac1, dac2;
   wire [4:0] ovld;
   wire [2:0] oi, ri, ei;
   wire smp, lamp, irq, dac_upd;
   logic [31:0] rd_q[$];
   los_exp_t out_q[$];
   int fails = 0, checks_done = 0;
   logic [7:0] ra[6] = '{`LOS_ADDR_CTRL, `LOS_ADDR_GAIN, `LOS_ADDR_STS, `LOS_ADDR_MASK, `LOS_ADDR_RECIP3, 8'h40};
   logic [31:0] rv[6] = '{32'h0, `LOS_GAIN_RST, 32'h0, 32'h0, `LOS_ONE, 32'h0};
   los_top #(.UPD_CYC(16)) i_dut (.clk_i, .nrst_i, .addr_i, .wdata_i, .we_i, .re_i, .rdata_o, .x_i, .y_i, .r_i,
      .phase_i, .aux3_i, .aux4_i, .sample_o(smp), .rear_x_o(rx), .rear_y_o(ry), .front_output_one_o(f1),
      .front_output_two_o(f2), .bar_r_o(bar), .ovld_o(ovld), .ratio_lamp_o(lamp), .ofs_ind_o(oi),
      .ratio_ind_o(ri), .exp_ind_o(ei), .irq_o(irq));
   los_dac_model i_dac (.clk_i, .sample_i(smp), .code1_i(f1), .code2_i(f2), .upd_o(dac_upd), .held1_o(dac1),
      .held2_o(dac2));
   // ============================================================
   // Clock, helpers and compare tasks.
   initial begin
      forever #5 clk_i = ~clk_i;
   end
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return s[0] ? (s >> 1) ^ 32'hA3000000 : s >> 1;
   endfunction
   function automatic logic [15:0] code(input logic [31:0] v);
      return 16'((64'(v) * 64'h7FFF) >> 16);
   endfunction
   task automatic cmp_word(input logic [31:0] act, input logic [31:0] exp_v);
      checks_done++;
      if (act !== exp_v) begin
         fails++;
         $display("MISMATCH t=%0t got %h exp %h", $time, act, exp_v);
      end
   endtask
   task automatic cmp_out(input los_exp_t act, input los_exp_t exp_v);
      checks_done++;
      if (act !== exp_v) begin
         fails++;
         $display("MISMATCH t=%0t got %h exp %h", $time, act, exp_v);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      we_i <= 1'b1;
      addr_i <= a;
      wdata_i <= d;
      @(posedge clk_i);
      we_i <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge clk_i);
      re_i <= 1'b1;
      addr_i <= a;
      rd_q.push_back(e);
      @(posedge clk_i);
      re_i <= 1'b0;
   endtask
   // Lets inputs and reciprocals settle, then notes the codes of the next update.
   task automatic expo(input logic [15:0] e1, input logic [15:0] e2, input logic [4:0] ov);
      repeat (6) @(posedge clk_i iff smp);
      repeat (2) @(posedge clk_i);
      out_q.push_back('{e1, e2, ov});
      @(posedge clk_i iff smp);
      repeat (2) @(posedge clk_i);
   endtask
   task automatic give_verdict();
      $display("checks_done %0d fails %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // Monitor: pops the oldest note whenever read data or an update appears.
   always @(posedge clk_i) begin
      if (re_d) cmp_word(rdata_o, rd_q.pop_front());
      re_d <= re_i;
      if (dac_upd === 1'b1 && out_q.size() > 0) cmp_out({dac1, dac2, ovld}, out_q.pop_front());
   end
   initial begin
      repeat (20000) @(posedge clk_i);
      fails++;
      give_verdict();
   end
   // ============================================================
   // Main sequence.
   initial begin
      repeat (10) @(posedge clk_i);
      nrst_i <= 1'b1;
      for (int i = 0; i < 6; i++) rd(ra[i], rv[i]);
      x_i <= 32'h00008000;
      for (int i = 0; i < 4; i++) begin
         seed = lfsr(seed);
         y_i <= {16'h0000, seed[15:0]};
         expo(16'h3FFF, code({16'h0000, seed[15:0]}), 5'h00);
      end
      wr(`LOS_ADDR_MASK, 32'h1);
      x_i <= 32'h00018000;
      y_i <= 32'h0;
      expo(`LOS_FS, 16'h0000, 5'h09);
      rd(`LOS_ADDR_DISP_X, `LOS_ONE);
      rd(`LOS_ADDR_CHART_X, 32'h00018000);
      rd(`LOS_ADDR_STS, 32'h9);
      cmp_word({31'h0, irq}, 32'h1);
      x_i <= 32'hFFFE8000;
      expo(`LOS_FS_NEG, 16'h0000, 5'h09);
      x_i <= 32'h00008000;
      expo(16'h3FFF, 16'h0000, 5'h00);
      wr(`LOS_ADDR_STS, 32'h1F);
      rd(`LOS_ADDR_STS, 32'h0);
      cmp_word({31'h0, irq}, 32'h0);
      wr(`LOS_ADDR_CTRL, 32'h6);
      r_i <= 32'h00008000;
      phase_i <= `LOS_PH_MIN;
      expo(16'h3FFF, `LOS_FS_NEG, 5'h00);
      cmp_word({16'h0, bar}, 32'h00003FFF);
      r_i <= 32'h00018000;
      phase_i <= 16'h0000;
      expo(`LOS_FS, 16'h0000, 5'h0C);
      r_i <= 32'h0;
      wr(`LOS_ADDR_CTRL, 32'h0);
      wr(`LOS_ADDR_OFS_X, 32'h32);
      wr(`LOS_ADDR_GAIN, 32'h00020000);
      y_i <= 32'h00004000;
      expo(16'h3FFF, 16'h3FFF, 5'h00);
      rd(`LOS_ADDR_OFS_X, 32'h32);
      cmp_word({29'h0, oi}, 32'h1);
      wr(`LOS_ADDR_OFS_X, 32'h3FF);
      rd(`LOS_ADDR_OFS_X, 32'h3E7);
      wr(`LOS_ADDR_OFS_X, 32'hFFFFFC00);
      rd(`LOS_ADDR_OFS_X, 32'hFFFFFC19);
      wr(`LOS_ADDR_OFS_X, 32'h0);
      wr(`LOS_ADDR_GAIN, `LOS_GAIN_RST);
      wr(`LOS_ADDR_CTRL, 32'h10);
      x_i <= 32'h00001000;
      y_i <= 32'h0;
      expo(16'h4FFF, 16'h0000, 5'h00);
      rd(`LOS_ADDR_DISP_X, 32'h00001000);
      cmp_word({29'h0, ei}, 32'h1);
      wr(`LOS_ADDR_CTRL, 32'h20);
      x_i <= 32'h00000100;
      expo(16'h31FF, 16'h0000, 5'h00);
      x_i <= 32'h00002000;
      expo(`LOS_FS, 16'h0000, 5'h09);
      wr(`LOS_ADDR_CTRL, 32'h1);
      aux3_i <= 32'h00020000;
      x_i <= `LOS_ONE;
      expo(16'h3FFF, 16'h0000, 5'h00);
      rd(`LOS_ADDR_RECIP3, 32'h00008000);
      rd(`LOS_ADDR_DISP_X, 32'h00008000);
      cmp_word({31'h0, lamp}, 32'h1);
      cmp_word({29'h0, ri}, 32'h3);
      rd(`LOS_ADDR_LIVE, 32'h00004300);
      rd(`LOS_ADDR_RECIP4, `LOS_ONE);
      repeat (4) @(posedge clk_i);
      give_verdict();
   end
endmodule
`default_nettype wire
